// file: shared/uscr_pkg.sv
package uscr_pkg;

  // Register offsets as printed are not all multiples of four, so they are indices.
  localparam logic [7:0] IDX_SYS_CLK_CTRL = 8'h22;
  localparam logic [7:0] IDX_LINE_STATE = 8'h40;
  localparam logic [7:0] IDX_EP_DIR_TOGGLE = 8'h41;
  localparam logic [7:0] IDX_EP_HALT = 8'h43;
  localparam logic [7:0] IDX_EP_ACCESS = 8'h44;
  localparam logic [7:0] IDX_ENGINE_STATUS = 8'h45;
  localparam logic [7:0] IDX_EP_ENABLES = 8'h47;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h50;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h51;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h52;

  // System clock control field positions.
  localparam int SCC_CLK_GATE = 3;
  localparam int SCC_BANDGAP = 4;
  localparam int SCC_LEGACY = 5;
  localparam int SCC_FREQ = 6;
  localparam int SCC_TEMP_ADJ = 7;
  localparam logic [7:0] SCC_WMASK = 8'hf8;
  localparam logic [7:0] SCC_RESET = 8'h00;

  // Endpoint register reset values and masks, plus the line-state mask.
  localparam logic [7:0] EP_RESET = 8'h07;
  localparam logic [7:0] EP_ACCESS_RESET = 8'h00;
  localparam logic [7:0] EP_MASK = 8'h07;
  localparam logic [7:0] LINE_MASK = 8'h1f;

  // Engine status field positions.
  localparam int ES_ADDR_DEFER = 0;
  localparam int ES_FIFO0_ERR = 1;
  localparam int ES_NAK_SUPP = 7;
  localparam logic [7:0] ES_MASK = 8'h83;
  localparam logic [7:0] ES_RESET = 8'h00;

  // Interrupt status bits: 0..4 line events, 5 fifo0 error, 6 ep0 interrupt, 7 ep access.
  localparam int IRQ_FIFO0_ERR = 5;
  localparam int IRQ_EP0 = 6;
  localparam int IRQ_EP_ACCESS = 7;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // Toggle reset needs a low pulse of at least 10 instruction cycles.
  localparam int TOGGLE_LOW_MIN_CYC = 10;
  localparam int TOGGLE_CNT_W = 4;

  // Events from the interface engine, all one-cycle pulses.
  typedef struct packed {
    logic eop;
    logic j_state;
    logic k_state;
    logic se0_noise;
    logic se1_noise;
    logic fifo0_error;
    logic [2:0] ep_access;
    logic ep0_data_moved;
    logic in_read_done;
    logic addr_written;
  } uscr_engine_ev_s;

  // Controls driven towards the engine and the analog parts.
  typedef struct packed {
    logic bus_clock_gate;
    logic bandgap_shutdown;
    logic legacy_mouse_mode_flag;
    logic oscillator_freq_select;
    logic temp_adjust_disable;
    logic [1:0] ep_dir_in;
    logic [2:0] ep_halt;
    logic [2:0] ep_enable;
    logic toggle_reset;
    logic adopt_address;
  } uscr_ctrl_s;

endpackage

// file: hdl/uscr_sticky.sv
`timescale 1ns/1ps
module uscr_sticky (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Set and clear.
  input wire logic [7:0] set_bits,
  input wire logic [7:0] clr_bits,
  input wire logic [7:0] reset_value,
  // Flags.
  output logic [7:0] flags
);

  typedef struct packed {
    logic [7:0] flags;
  } uscr_sticky_state_s;

  uscr_sticky_state_s state;
  uscr_sticky_state_s next_state;

  // Set wins over clear so an event in the clearing cycle is kept.
  always_comb begin
    next_state = state;
    next_state.flags = (state.flags & ~clr_bits) | set_bits;
  end

  // Reset value is a port but is applied synchronously, so no async hazard.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state.flags <= reset_value;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign flags = state.flags;

endmodule

// file: hdl/uscr_toggle_pulse.sv
`timescale 1ns/1ps
module uscr_toggle_pulse (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Toggle bit from the register.
  input wire logic toggle_bit,
  // One-cycle request to clear data toggles.
  output logic toggle_reset
);

  typedef struct packed {
    logic [uscr_pkg::TOGGLE_CNT_W-1:0] low_cnt;
    logic fired;
    logic pulse;
  } uscr_toggle_state_s;

  uscr_toggle_state_s state;
  uscr_toggle_state_s next_state;

  // Count low cycles; a short glitch low does not clear the toggles.
  always_comb begin
    next_state = state;
    next_state.pulse = 1'b0;
    if (toggle_bit) begin
      next_state.low_cnt = '0;
      next_state.fired = 1'b0;
    end else if (!state.fired) begin
      if (32'(state.low_cnt) + 1 >= uscr_pkg::TOGGLE_LOW_MIN_CYC) begin
        next_state.pulse = 1'b1;
        next_state.fired = 1'b1;
      end else begin
        next_state.low_cnt = state.low_cnt + 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign toggle_reset = state.pulse;

endmodule

// file: hdl/uscr_regs.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module uscr_regs (
  // Clock, enable and reset.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Engine side.
  input wire logic usb_mode,
  input wire uscr_pkg::uscr_engine_ev_s engine_ev,
  output uscr_pkg::uscr_ctrl_s ctrl,
  // Interrupt.
  output logic irq
);

  typedef struct packed {
    logic [7:0] system_clock_control;
    logic [7:0] ep_dir;
    logic [7:0] ep_halt;
    logic [7:0] ep_en;
    logic [7:0] es_cfg;
    logic [7:0] irq_en;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
    logic adopt;
    uscr_pkg::uscr_ctrl_s ctrl;
  } uscr_regs_state_s;

  uscr_regs_state_s state;
  uscr_regs_state_s next_state;

  logic [7:0] line_flags;
  logic [7:0] access_flags;
  logic [7:0] err_flags;
  logic [7:0] irq_flags;
  logic [7:0] line_set;
  logic [7:0] line_clr;
  logic [7:0] access_set;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;
  logic toggle_reset;
  logic apb_setup;
  logic wr_en;
  logic [7:0] wbyte;
  logic ep0_irq_event;

  // Word address check: the printed index times four, low bits zero.
  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr == {2'b00, idx, 2'b00});
  endfunction

  // Reads are decoded in the setup phase and answered one cycle later.
  // Writes land only at the access edge where pready is seen high, as the master expects.
  assign apb_setup = psel && !penable && !state.ready;
  assign wr_en = psel && penable && pwrite && state.ready;
  assign wbyte = pwdata[7:0];

  // The endpoint 0 interrupt drops NAK accesses when suppression is on.
  assign ep0_irq_event = engine_ev.ep_access[0] &&
    (!state.es_cfg[uscr_pkg::ES_NAK_SUPP] || engine_ev.ep0_data_moved);

  // Line-state flags: engine events set, firmware writing 0 clears.
  assign line_set = {3'b000, engine_ev.se1_noise, engine_ev.se0_noise,
    engine_ev.k_state, engine_ev.j_state, engine_ev.eop};
  assign line_clr = (wr_en && hit(paddr, uscr_pkg::IDX_LINE_STATE)) ?
    (~wbyte & uscr_pkg::LINE_MASK) : 8'h00;

  // Endpoint access flags are read-only; nothing but reset clears them.
  assign access_set = {5'b00000, engine_ev.ep_access};

  // The FIFO0 error flag lives in the engine status register.
  assign err_set = {6'b000000, engine_ev.fifo0_error, 1'b0};
  assign err_clr = (wr_en && hit(paddr, uscr_pkg::IDX_ENGINE_STATUS) &&
    !wbyte[uscr_pkg::ES_FIFO0_ERR]) ? 8'h02 : 8'h00;

  // Interrupt sources collected from the line, fifo0 error and endpoint access events.
  assign irq_set = {|engine_ev.ep_access, ep0_irq_event, engine_ev.fifo0_error,
    line_set[4:0]};
  assign irq_clr = (wr_en && hit(paddr, uscr_pkg::IDX_IRQ_CLEAR)) ? wbyte : 8'h00;

  uscr_sticky u_line (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .set_bits(line_set),
    .clr_bits(line_clr),
    .reset_value(8'h00),
    .flags(line_flags)
  );

  uscr_sticky u_access (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .set_bits(access_set),
    .clr_bits(8'h00),
    .reset_value(uscr_pkg::EP_ACCESS_RESET),
    .flags(access_flags)
  );

  uscr_sticky u_err (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .set_bits(err_set),
    .clr_bits(err_clr),
    .reset_value(8'h00),
    .flags(err_flags)
  );

  uscr_sticky u_irq (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .set_bits(irq_set),
    .clr_bits(irq_clr),
    .reset_value(uscr_pkg::IRQ_RESET),
    .flags(irq_flags)
  );

  uscr_toggle_pulse u_toggle (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .toggle_bit(state.ep_dir[0]),
    .toggle_reset(toggle_reset)
  );

  // Register writes, read mux, address deferral and output staging.
  always_comb begin
    next_state = state;
    next_state.ready = apb_setup;
    next_state.err = 1'b0;
    next_state.adopt = 1'b0;
    if (apb_setup || wr_en) begin
      next_state.rdata = 32'h0000_0000;
      if (hit(paddr, uscr_pkg::IDX_SYS_CLK_CTRL)) begin
        next_state.rdata = {24'h000000, state.system_clock_control};
        if (wr_en) begin
          next_state.system_clock_control = wbyte & uscr_pkg::SCC_WMASK;
          // The band-gap cannot be shut down while in bus mode.
          if (usb_mode) begin
            next_state.system_clock_control[uscr_pkg::SCC_BANDGAP] = 1'b0;
          end
        end
      end else if (hit(paddr, uscr_pkg::IDX_LINE_STATE)) begin
        next_state.rdata = {24'h000000, line_flags & uscr_pkg::LINE_MASK};
      end else if (hit(paddr, uscr_pkg::IDX_EP_DIR_TOGGLE)) begin
        next_state.rdata = {24'h000000, state.ep_dir};
        if (wr_en) begin
          next_state.ep_dir = wbyte & uscr_pkg::EP_MASK;
        end
      end else if (hit(paddr, uscr_pkg::IDX_EP_HALT)) begin
        next_state.rdata = {24'h000000, state.ep_halt};
        if (wr_en) begin
          next_state.ep_halt = wbyte & uscr_pkg::EP_MASK;
        end
      end else if (hit(paddr, uscr_pkg::IDX_EP_ACCESS)) begin
        next_state.rdata = {24'h000000, access_flags & uscr_pkg::EP_MASK};
      end else if (hit(paddr, uscr_pkg::IDX_ENGINE_STATUS)) begin
        next_state.rdata = {24'h000000,
          (state.es_cfg | err_flags) & uscr_pkg::ES_MASK};
        if (wr_en) begin
          next_state.es_cfg[uscr_pkg::ES_ADDR_DEFER] = wbyte[uscr_pkg::ES_ADDR_DEFER];
          next_state.es_cfg[uscr_pkg::ES_NAK_SUPP] = wbyte[uscr_pkg::ES_NAK_SUPP];
        end
      end else if (hit(paddr, uscr_pkg::IDX_EP_ENABLES)) begin
        next_state.rdata = {24'h000000, state.ep_en};
        if (wr_en) begin
          next_state.ep_en = wbyte & uscr_pkg::EP_MASK;
        end
      end else if (hit(paddr, uscr_pkg::IDX_IRQ_STATUS)) begin
        next_state.rdata = {24'h000000, irq_flags};
      end else if (hit(paddr, uscr_pkg::IDX_IRQ_ENABLE)) begin
        next_state.rdata = {24'h000000, state.irq_en};
        if (wr_en) begin
          next_state.irq_en = wbyte;
        end
      end else if (!hit(paddr, uscr_pkg::IDX_IRQ_CLEAR) && apb_setup) begin
        next_state.err = 1'b1;
      end
    end
    // Deferred address: adopt after a completed IN read, then drop the bit.
    if (state.es_cfg[uscr_pkg::ES_ADDR_DEFER]) begin
      if (engine_ev.in_read_done) begin
        next_state.adopt = 1'b1;
        next_state.es_cfg[uscr_pkg::ES_ADDR_DEFER] = 1'b0;
      end
    end else if (engine_ev.addr_written) begin
      next_state.adopt = 1'b1;
    end
    // Band-gap shutdown is also forced off on entering bus mode.
    if (usb_mode) begin
      next_state.system_clock_control[uscr_pkg::SCC_BANDGAP] = 1'b0;
    end
    // Outputs staged through flops.
    next_state.ctrl.bus_clock_gate = next_state.system_clock_control[uscr_pkg::SCC_CLK_GATE];
    next_state.ctrl.bandgap_shutdown = next_state.system_clock_control[uscr_pkg::SCC_BANDGAP];
    next_state.ctrl.legacy_mouse_mode_flag = next_state.system_clock_control[uscr_pkg::SCC_LEGACY];
    next_state.ctrl.oscillator_freq_select = next_state.system_clock_control[uscr_pkg::SCC_FREQ];
    next_state.ctrl.temp_adjust_disable = next_state.system_clock_control[uscr_pkg::SCC_TEMP_ADJ];
    next_state.ctrl.ep_dir_in = next_state.ep_dir[2:1];
    next_state.ctrl.ep_halt = next_state.ep_halt[2:0];
    // Endpoint 0 always stays enabled regardless of its bit.
    next_state.ctrl.ep_enable = {next_state.ep_en[2:1], 1'b1};
    next_state.ctrl.toggle_reset = toggle_reset;
    next_state.ctrl.adopt_address = next_state.adopt;
    next_state.irq = |(irq_flags & state.irq_en);
  end

  // One register for this module's state, with flags and toggle counter in the submodules; reset values applied synchronously.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= '0;
      state.system_clock_control <= uscr_pkg::SCC_RESET;
      state.ep_dir <= uscr_pkg::EP_RESET;
      state.ep_halt <= uscr_pkg::EP_RESET;
      state.ep_en <= uscr_pkg::EP_RESET;
      state.es_cfg <= uscr_pkg::ES_RESET;
      state.ctrl.ep_dir_in <= 2'b11;
      state.ctrl.ep_halt <= 3'b111;
      state.ctrl.ep_enable <= 3'b111;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.err;
  assign ctrl = state.ctrl;
  assign irq = state.irq;

endmodule

// file: tb/uscr_regs_asserts.sv
`timescale 1ns/1ps
// Checks control outputs against bus writes; a write lands at its pready edge.
module uscr_regs_asserts (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // Bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic pready,
  // Engine side.
  input wire logic usb_mode,
  input wire uscr_pkg::uscr_ctrl_s ctrl,
  input wire logic irq
);
  logic wr;
  logic [7:0] wd_q;
  // Write data is kept one cycle so the effect can be compared after the edge.
  assign wr = psel && penable && pwrite && pready && clk_en;
  always_ff @(posedge clk_sys) begin
    wd_q <= pwdata[7:0];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  clk_gate_wr_a: assert property (
    wr && paddr == 12'h088 |=> ctrl.bus_clock_gate == wd_q[3]) else $error("clock gate");
  bandgap_wr_a: assert property (
    wr && paddr == 12'h088 && !usb_mode |=> ctrl.bandgap_shutdown == wd_q[4])
    else $error("bandgap write");
  bandgap_usb_a: assert property (
    usb_mode |=> !ctrl.bandgap_shutdown) else $error("bandgap in bus mode");
  scc_upper_a: assert property (
    wr && paddr == 12'h088 |=> {ctrl.temp_adjust_disable, ctrl.oscillator_freq_select,
    ctrl.legacy_mouse_mode_flag} == wd_q[7:5]) else $error("clock control fields");
  dir_wr_a: assert property (
    wr && paddr == 12'h104 |=> ctrl.ep_dir_in == wd_q[2:1]) else $error("direction");
  halt_wr_a: assert property (
    wr && paddr == 12'h10c |=> ctrl.ep_halt == wd_q[2:0]) else $error("halt");
  enable_wr_a: assert property (
    wr && paddr == 12'h11c |=> ctrl.ep_enable == {wd_q[2:1], 1'b1}) else $error("enable");
  ep0_enabled_a: assert property (
    ctrl.ep_enable[0]) else $error("endpoint 0 disabled");
  toggle_once_a: assert property (
    ctrl.toggle_reset |=> !ctrl.toggle_reset [*8]) else $error("toggle pulse repeats");
  reset_vals_a: assert property (
    $fell(reset) |-> ctrl.ep_halt == 3'h7 && ctrl.ep_dir_in == 2'h3 && ctrl.ep_enable == 3'h7)
    else $error("reset values");
  // Main scenarios.
  cover property (ctrl.toggle_reset);
  cover property (irq);
  cover property (pslverr);
endmodule

// file: tb/uscr_host_model.sv
`timescale 1ns/1ps
// Stand-in for the engine facing the host: one event pulse per request.
module uscr_host_model (
  // Clock.
  input wire logic clk_sys,
  // Request from the bench.
  input wire logic go,
  input wire logic [3:0] sel,
  // Events towards the block.
  output uscr_pkg::uscr_engine_ev_s ev
);
  // Index 0..4 line events, 5 fifo0 error, 6..8 endpoint 2..0, 9..11 the rest.
  // Pulses last one cycle, so any flag that sticks does so by the block alone.
  always_ff @(posedge clk_sys) begin
    ev <= go ? uscr_pkg::uscr_engine_ev_s'(12'h800 >> sel) : '0;
  end
endmodule

// file: tb/usb_sie_control_status_regs_bench.sv
`timescale 1ns/1ps
module usb_sie_control_status_regs_bench;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [7:0] rst; logic [7:0] ex;} uscr_row_s;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic usb_mode = 1'b0;
  logic go = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] rd;
  logic err;
  uscr_pkg::uscr_engine_ev_s ev;
  uscr_pkg::uscr_ctrl_s ctrl;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int i;
  int n;
  // Address, write data, reset value, value read back after the write.
  uscr_row_s rows [8] = '{'{12'h088, 32'hff, 8'h00, 8'hf8}, '{12'h100, 32'h00, 8'h00, 8'h00},
    '{12'h104, 32'h03, 8'h07, 8'h03}, '{12'h10c, 32'h05, 8'h07, 8'h05},
    '{12'h110, 32'hff, 8'h00, 8'h00}, '{12'h11c, 32'h03, 8'h07, 8'h03},
    '{12'h114, 32'h81, 8'h00, 8'h81}, '{12'h140, 32'hff, 8'h00, 8'h00}};

  uscr_regs dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .usb_mode(usb_mode), .engine_ev(ev), .ctrl(ctrl),
    .irq(irq));
  uscr_host_model host_u (.clk_sys(clk_sys), .go(go), .sel(sel), .ev(ev));

  // Clock and a cycle ceiling well above the roughly two hundred cycles the run needs.
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One transfer, then an idle cycle so psel is never reassigned in one step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rreg(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, rd, err);
    chk8("register", e, rd[7:0]);
  endtask

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  // Event pulse, then enough cycles for flag and interrupt to show.
  task automatic fire(input logic [3:0] k);
    go <= 1'b1;
    sel <= k;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (i = 0; i < 8; i++) begin
      rreg(rows[i].a, rows[i].rst);
      wreg(rows[i].a, rows[i].w);
      rreg(rows[i].a, rows[i].ex);
    end
    $display("Test register table done");
    usb_mode <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rreg(12'h088, 8'he8);
    wreg(12'h088, 32'h10);
    rreg(12'h088, 8'h00);
    usb_mode <= 1'b0;
    $display("Test bus mode done");
    for (i = 0; i < 5; i++) fire(i[3:0]);
    rreg(12'h100, 8'h1f);
    // The event reaches the block at the very edge the clearing write lands.
    fork
      wreg(12'h100, 32'h0);
      begin
        go <= 1'b1;
        sel <= 4'h0;
        @(posedge clk_sys);
        go <= 1'b0;
      end
    join
    rreg(12'h100, 8'h01);
    $display("Test line flags done");
    wreg(12'h148, 32'hff);
    wreg(12'h144, 32'h01);
    fire(4'h3);
    chk8("irq masked", 8'h00, {7'h0, irq});
    fire(4'h0);
    chk8("irq raised", 8'h01, {7'h0, irq});
    rreg(12'h140, 8'h09);
    wreg(12'h148, 32'h09);
    @(posedge clk_sys);
    chk8("irq cleared", 8'h00, {7'h0, irq});
    $display("Test interrupt done");
    fire(4'h6);
    rreg(12'h110, 8'h04);
    fire(4'h5);
    fire(4'ha);
    rreg(12'h114, 8'h82);
    wreg(12'h114, 32'h80);
    rreg(12'h114, 8'h80);
    wreg(12'h148, 32'hff);
    fire(4'h8);
    rreg(12'h140, 8'h80);
    wreg(12'h114, 32'h00);
    fire(4'h8);
    rreg(12'h140, 8'hc0);
    $display("Test engine status done");
    wreg(12'h104, 32'h06);
    n = 0;
    while (ctrl.toggle_reset !== 1'b1 && n < 30) begin
      @(posedge clk_sys);
      n++;
    end
    chk8("toggle delay", 8'h01, {7'h0, n >= 8 && n < 30});
    wreg(12'h104, 32'h07);
    $display("Test toggle done");
    apb(1'b0, 12'h0fc, 32'h0, rd, err);
    chk8("unmapped", 8'h01, {7'h0, err});
    apb(1'b1, 12'h089, 32'hff, rd, err);
    chk8("misaligned", 8'h01, {7'h0, err});
    rreg(12'h088, 8'h00);
    $display("Test refusals done");
    conclude();
  end
endmodule

bind uscr_regs uscr_regs_asserts chk_u (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pslverr(pslverr), .pready(pready), .usb_mode(usb_mode), .ctrl(ctrl), .irq(irq));
